// >>> pkg/tag_cfg_pkg.sv
// Shared constants and types for the tag configuration and control registers
package tag_cfg_pkg;
	// System area byte locations seen from the serial side
	localparam logic [15:0] CFG_ADDR  = 16'h0910;
	localparam logic [15:0] CTRL_ADDR = 16'h0920;

	// Configuration byte fields
	localparam int PIN_MODE_BIT    = 3;
	localparam int HARVEST_SEL_BIT = 2;
	localparam int SINK_HI_BIT     = 1;
	localparam int SINK_LO_BIT     = 0;

	// Control register fields
	localparam int WR_DONE_BIT  = 7;
	localparam int FIELD_BIT    = 1;
	localparam int HARVEST_BIT  = 0;

	// Value held before the stored byte has been fetched
	localparam logic [7:0] CFG_RESET  = 8'hF4;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [7:0] HARV_MASK  = 8'h07;
	localparam logic [7:0] MODE_MASK  = 8'h08;

	// Pin mode encodings of the mode bit
	localparam logic PIN_MODE_BUSY = 1'b0;
	localparam logic PIN_MODE_WIP  = 1'b1;

	// Dedicated RF commands handed over by the protocol engine
	typedef enum logic [2:0] {
		RF_NOP_CMD,
		RF_READ_CONFIG_CMD,
		RF_WRITE_HARVEST_CFG_CMD,
		RF_WRITE_PIN_MODE_CMD,
		RF_READ_CONTROL_CMD,
		RF_SET_HARVEST_EN_CMD
	} rf_cmd_t;

	// Activity tracking of one RF frame
	typedef enum logic [1:0] {
		ACT_IDLE,
		ACT_RX,
		ACT_EXEC
	} act_state_t;
endpackage

// >>> rtl/rf_tag_config_and_control_regs.sv
// Configuration byte, control register, activity pin and harvest gating of the tag
`timescale 1ns/1ps

// Operation
// [RL1] Eight-bit non-volatile configuration byte at system location 2320.
// [RL2] Eight-bit volatile control register at system location 2336.
// [RL3] Configuration bit 3 picks pin mode: 0 busy, 1 write in progress.
// [RL4] Busy mode: pin low from RF start-of-frame until command execution ends.
// [RL5] Busy mode, bad command: pin low only from start-of-frame until CRC received.
// [RL6] Field loss releases a low-driven activity pin at once.
// [RL7] Busy mode: pin stays released while serial commands execute.
// [RL8] Write mode: pin low during internal RF write, ending when answer begins.
// [RL9] Write mode: pin stays released during serial write operations.
// [RL10] Bits 7-4 ignored, bit 3 pin mode, bit 2 harvest default, 1-0 sink.
// [RL11] Four sink current levels from configuration bits 1 and 0.
// [RL12] Harvest output on only when enable bit set and RF power sufficient.
// [RL13] Control bits 7 to 1 are read-only; only bit 0 is writable.
// [RL14] Write-done flag cleared at reset and cycle start, set on good completion.
// [RL15] At power-up harvest enable loads the inverse of the stored default selector.
// [RL16] Control bit 1 shows whether RF power suffices for commands.
// [RL17] RF reads of the control register return the power bit as 1.
// [RL18] Serial master may always read and write the configuration byte with select.
// [RL19] Serial master may always read and write the control register with select.
// [RL20] RF: read configuration, write harvest fields, write pin mode bit.
// [RL21] New configuration takes effect right after any write.
// [RL22] RF: read all control bits, and set or clear harvest enable.
// [RL23] RF reads of the control register return the write-done flag as 0.
// [RL24] Control bits 2 through 6 read as zero.
// [RL25] Writes to read-only control bits are ignored.
// [RL26] Activity pin is only driven low or released, never driven high.
module rf_tag_config_and_control_regs (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	input  wire logic [7:0]           nv_cfg_in,
	output logic      [7:0]           nv_cfg_out,
	input  wire logic                 i2c_req_in,
	input  wire logic                 i2c_we_in,
	input  wire logic                 system_area_select_in,
	input  wire logic [15:0]          i2c_addr_in,
	input  wire logic [7:0]           i2c_wdata_in,
	output logic      [7:0]           i2c_rdata_out,
	output logic                      i2c_rvalid_out,
	input  wire logic                 i2c_active_in,
	input  wire logic                 wcycle_start_in,
	input  wire logic                 wcycle_ok_in,
	input  wire logic                 rf_cmd_valid_in,
	input  wire tag_cfg_pkg::rf_cmd_t rf_cmd_in,
	input  wire logic [7:0]           rf_wdata_in,
	output logic      [7:0]           rf_rdata_out,
	output logic                      rf_rvalid_out,
	input  wire logic                 rf_sof_in,
	input  wire logic                 rf_crc_in,
	input  wire logic                 rf_bad_in,
	input  wire logic                 rf_exec_done_in,
	input  wire logic                 rf_wr_start_in,
	input  wire logic                 rf_answer_in,
	input  wire logic                 rf_field_in,
	input  wire logic                 rf_power_ok_in,
	output logic                      rf_activity_pin_out,
	output logic                      rf_activity_pin_oe_out,
	output logic                      harvest_out_en_out,
	output logic                      sink_level_hi_out,
	output logic                      sink_level_lo_out
);

	logic            loaded_q, loaded_d;
	logic [7:0]      cfg_q, cfg_d;
	logic            harv_en_q, harv_en_d;
	logic            wr_done_q, wr_done_d;
	logic            field_q, field_d;
	logic [7:0]      i2c_rd_q, i2c_rd_d;
	logic            i2c_rv_q, i2c_rv_d;
	logic [7:0]      rf_rd_q, rf_rd_d;
	logic            rf_rv_q, rf_rv_d;
	tag_cfg_pkg::act_state_t act_q, act_d;
	logic            wip_q, wip_d;
	logic            oe_q, oe_d;
	logic            harv_out_q, harv_out_d;
	logic            i2c_hit_cfg, i2c_hit_ctrl;
	logic [7:0]      ctrl_view;

	// Serial decode only hits with the system area selected; other reads still answer with zero
	assign i2c_hit_cfg  = i2c_req_in && system_area_select_in
			&& (i2c_addr_in == tag_cfg_pkg::CFG_ADDR);     // [RL1] [RL18]
	assign i2c_hit_ctrl = i2c_req_in && system_area_select_in
			&& (i2c_addr_in == tag_cfg_pkg::CTRL_ADDR);    // [RL2] [RL19]

	// Control register as the serial side sees it; spare bits stay zero
	always_comb
	begin
		ctrl_view = tag_cfg_pkg::BYTE_ZERO;                    // [RL24]
		ctrl_view[tag_cfg_pkg::WR_DONE_BIT] = wr_done_q;
		ctrl_view[tag_cfg_pkg::FIELD_BIT]   = field_q;         // [RL16]
		ctrl_view[tag_cfg_pkg::HARVEST_BIT] = harv_en_q;
	end

	// Register bank next state: both interfaces write the same storage
	always_comb
	begin
		loaded_d  = 1'b1;
		cfg_d     = cfg_q;
		harv_en_d = harv_en_q;
		wr_done_d = wr_done_q;
		field_d   = rf_field_in && rf_power_ok_in;         // [RL16]
		i2c_rd_d  = tag_cfg_pkg::BYTE_ZERO;
		i2c_rv_d  = 1'b0;
		rf_rd_d   = tag_cfg_pkg::BYTE_ZERO;
		rf_rv_d   = 1'b0;
		// Stored byte is fetched once after reset, never under the reset itself
		if (!loaded_q)
		begin
			cfg_d     = nv_cfg_in;
			harv_en_d = ~nv_cfg_in[tag_cfg_pkg::HARVEST_SEL_BIT];  // [RL15]
		end
		// Completion beats a start arriving in the same cycle
		if (wcycle_start_in)
			wr_done_d = 1'b0;                                  // [RL14]
		if (wcycle_ok_in)
			wr_done_d = 1'b1;                                  // [RL14]
		// Serial access
		if (i2c_req_in)
		begin
			i2c_rv_d = !i2c_we_in;
			if (i2c_hit_cfg && i2c_we_in)
				cfg_d = i2c_wdata_in;                          // [RL18] [RL21]
			if (i2c_hit_ctrl && i2c_we_in)
				harv_en_d = i2c_wdata_in[tag_cfg_pkg::HARVEST_BIT]; // [RL13] [RL25]
			if (i2c_hit_cfg)
				i2c_rd_d = cfg_q;
			else if (i2c_hit_ctrl)
				i2c_rd_d = ctrl_view;                          // [RL19]
		end
		// Dedicated RF commands
		if (rf_cmd_valid_in)
		begin
			case (rf_cmd_in)
				tag_cfg_pkg::RF_READ_CONFIG_CMD:
				begin
					rf_rd_d = cfg_q;                           // [RL20]
					rf_rv_d = 1'b1;
				end
				tag_cfg_pkg::RF_WRITE_HARVEST_CFG_CMD:
					cfg_d = (cfg_q & ~tag_cfg_pkg::HARV_MASK)
						| (rf_wdata_in & tag_cfg_pkg::HARV_MASK);  // [RL20] [RL21]
				tag_cfg_pkg::RF_WRITE_PIN_MODE_CMD:
					cfg_d = (cfg_q & ~tag_cfg_pkg::MODE_MASK)
						| (rf_wdata_in & tag_cfg_pkg::MODE_MASK);  // [RL20] [RL21]
				tag_cfg_pkg::RF_READ_CONTROL_CMD:
				begin
					rf_rd_d = tag_cfg_pkg::BYTE_ZERO;          // [RL23] [RL24]
					rf_rd_d[tag_cfg_pkg::FIELD_BIT]   = 1'b1;  // [RL17]
					rf_rd_d[tag_cfg_pkg::HARVEST_BIT] = harv_en_q; // [RL22]
					rf_rv_d = 1'b1;
				end
				tag_cfg_pkg::RF_SET_HARVEST_EN_CMD:
					harv_en_d = rf_wdata_in[tag_cfg_pkg::HARVEST_BIT]; // [RL22]
				default:
					rf_rv_d = 1'b0;
			endcase
		end
	end

	// Register bank storage
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			loaded_q  <= 1'b0;
			cfg_q     <= tag_cfg_pkg::CFG_RESET;
			harv_en_q <= 1'b0;
			wr_done_q <= 1'b0;                                 // [RL14]
			field_q   <= 1'b0;
			i2c_rd_q  <= tag_cfg_pkg::BYTE_ZERO;
			i2c_rv_q  <= 1'b0;
			rf_rd_q   <= tag_cfg_pkg::BYTE_ZERO;
			rf_rv_q   <= 1'b0;
		end
		else
		begin
			loaded_q  <= loaded_d;
			cfg_q     <= cfg_d;
			harv_en_q <= harv_en_d;
			wr_done_q <= wr_done_d;
			field_q   <= field_d;
			i2c_rd_q  <= i2c_rd_d;
			i2c_rv_q  <= i2c_rv_d;
			rf_rd_q   <= rf_rd_d;
			rf_rv_q   <= rf_rv_d;
		end
	end

	// Activity tracking and pin drive; field loss overrides every other event
	always_comb
	begin
		act_d      = act_q;
		wip_d      = wip_q;
		harv_out_d = harv_en_q && rf_power_ok_in;              // [RL12]
		case (act_q)
			tag_cfg_pkg::ACT_IDLE:
				if (rf_sof_in)
					act_d = tag_cfg_pkg::ACT_RX;               // [RL4]
			tag_cfg_pkg::ACT_RX:
				if (rf_crc_in)
					act_d = rf_bad_in ? tag_cfg_pkg::ACT_IDLE
						: tag_cfg_pkg::ACT_EXEC;               // [RL5]
			tag_cfg_pkg::ACT_EXEC:
				if (rf_exec_done_in)
					act_d = tag_cfg_pkg::ACT_IDLE;             // [RL4]
			default:
				act_d = tag_cfg_pkg::ACT_IDLE;
		endcase
		if (rf_wr_start_in)
			wip_d = 1'b1;                                      // [RL8]
		if (rf_answer_in)
			wip_d = 1'b0;                                      // [RL8]
		if (!rf_field_in)
		begin
			act_d = tag_cfg_pkg::ACT_IDLE;                     // [RL6]
			wip_d = 1'b0;                                      // [RL6]
		end
		// Mode bit is read live, so a rewrite applies on the next edge
		if (cfg_q[tag_cfg_pkg::PIN_MODE_BIT] == tag_cfg_pkg::PIN_MODE_WIP)
			oe_d = wip_d;                                      // [RL3] [RL8] [RL21]
		else
			oe_d = (act_d != tag_cfg_pkg::ACT_IDLE);           // [RL3] [RL4]
		// Serial traffic can overlap RF traffic; the pin is released while it runs, in either mode
		if (i2c_active_in)
			oe_d = 1'b0;                                       // [RL7] [RL9]
	end

	// Activity and harvest flops
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			act_q      <= tag_cfg_pkg::ACT_IDLE;
			wip_q      <= 1'b0;
			oe_q       <= 1'b0;
			harv_out_q <= 1'b0;
		end
		else
		begin
			act_q      <= act_d;
			wip_q      <= wip_d;
			oe_q       <= oe_d;
			harv_out_q <= harv_out_d;
		end
	end

	// Pin data is a constant low: only the enable toggles
	assign rf_activity_pin_out    = 1'b0;                      // [RL26]
	assign rf_activity_pin_oe_out = oe_q;
	assign harvest_out_en_out     = harv_out_q;
	assign sink_level_hi_out      = cfg_q[tag_cfg_pkg::SINK_HI_BIT];   // [RL10] [RL11]
	assign sink_level_lo_out      = cfg_q[tag_cfg_pkg::SINK_LO_BIT];   // [RL10] [RL11]
	assign nv_cfg_out             = cfg_q;
	assign i2c_rdata_out          = i2c_rd_q;
	assign i2c_rvalid_out         = i2c_rv_q;
	assign rf_rdata_out           = rf_rd_q;
	assign rf_rvalid_out          = rf_rv_q;

	// Checks
	AST_FIELD_RELEASE : assert property ( // [RL6]
		@(posedge mclk_in) disable iff (rst_in)
		!rf_field_in |=> !rf_activity_pin_oe_out)
		else $error("activity pin held after field loss");
	AST_BAD_CRC : assert property ( // [RL5]
		@(posedge mclk_in) disable iff (rst_in)
		(act_q == tag_cfg_pkg::ACT_RX) && rf_crc_in && rf_bad_in
		|=> (act_q == tag_cfg_pkg::ACT_IDLE))
		else $error("bad command kept pin busy after crc");
	AST_BUSY_SOF : assert property ( // [RL4]
		@(posedge mclk_in) disable iff (rst_in)
		(act_q == tag_cfg_pkg::ACT_IDLE) && rf_sof_in && rf_field_in && !i2c_active_in
		&& !cfg_q[tag_cfg_pkg::PIN_MODE_BIT] |=> rf_activity_pin_oe_out)
		else $error("busy pin not pulled at start of frame");
	AST_I2C_QUIET : assert property ( // [RL7]
		@(posedge mclk_in) disable iff (rst_in)
		i2c_active_in |=> !rf_activity_pin_oe_out)
		else $error("activity pin driven during serial access");
	AST_RF_CTRL_READ : assert property ( // [RL17]
		@(posedge mclk_in) disable iff (rst_in)
		rf_cmd_valid_in && (rf_cmd_in == tag_cfg_pkg::RF_READ_CONTROL_CMD)
		|=> rf_rvalid_out && (rf_rdata_out[7:1] == 7'h01))
		else $error("rf control read upper bits wrong");
	AST_HARVEST_GATE : assert property ( // [RL12]
		@(posedge mclk_in) disable iff (rst_in)
		harvest_out_en_out |-> $past(harv_en_q) && $past(rf_power_ok_in))
		else $error("harvest output enabled without enable and power");
	AST_POWERUP_EN : assert property ( // [RL15]
		@(posedge mclk_in) disable iff (rst_in)
		!loaded_q |=> (harv_en_q == ~cfg_q[tag_cfg_pkg::HARVEST_SEL_BIT]))
		else $error("harvest enable not inverse of default selector");
	AST_WR_DONE : assert property ( // [RL14]
		@(posedge mclk_in) disable iff (rst_in)
		$rose(wr_done_q) |-> $past(wcycle_ok_in))
		else $error("write done set without completion");
	AST_CTRL_ZERO : assert property ( // [RL24]
		@(posedge mclk_in) disable iff (rst_in)
		i2c_rvalid_out && $past(i2c_hit_ctrl) |-> (i2c_rdata_out[6:2] == 5'h00))
		else $error("reserved control bits not zero");

endmodule

// >>> tb/rf_frame_model.sv
// Behavioural RF frame source standing in for the reader and protocol engine
`timescale 1ns/1ps
module rf_frame_model (
	input  wire logic       mclk_in,
	input  wire logic       go_in,
	input  wire logic [1:0] kind_in,
	input  wire logic [3:0] gap_in,
	output logic      [4:0] ev_out,
	output logic            bad_out,
	output logic            busy_out
);
	logic [3:0] g;

	// One event pulse, then the idle gap; bits are sof, crc, done, write start, answer
	task automatic emit(input logic [4:0] e);
		ev_out = e;
		@(posedge mclk_in);
		#1;
		ev_out = 5'h00;
		bad_out = ~bad_out; // Qualifier is stale outside the CRC pulse, so it keeps moving
		repeat (g)
		begin
			@(posedge mclk_in);
			#1;
		end
	endtask

	// Frame order is fixed: start, CRC, then write phase for kind 2 only, and completion when valid
	initial
	begin
		ev_out = 5'h00;
		bad_out = 1'b1;
		busy_out = 1'b0;
		g = 4'h0;
		forever
		begin
			@(posedge mclk_in);
			if (go_in)
			begin
				#1;
				busy_out = 1'b1;
				g = gap_in;
				emit(5'h01);
				bad_out = (kind_in == 2'h1);
				emit(5'h02);
				if (kind_in == 2'h2)
				begin
					emit(5'h08);
					emit(5'h10);
				end
				if (kind_in != 2'h1)
					emit(5'h04);
				busy_out = 1'b0;
			end
		end
	end
endmodule

// >>> tb/rf_tag_config_and_control_regs_test.sv
// Self-checking bench for the tag configuration and control registers
`timescale 1ns/1ps
module rf_tag_config_and_control_regs_test;
	logic                 mclk, rst, req, we, sel, act, wst, wok, cv, field, pwr, go;
	logic                 rv, rrv, pin, oe, hen, shi, slo, bad, busy, v;
	logic [7:0]           nv, nv_o, wd, rd, rwd, rrd, cnt, r;
	logic [15:0]          addr;
	logic [1:0]           kind;
	logic [3:0]           gap;
	logic [4:0]           ev;
	tag_cfg_pkg::rf_cmd_t cmd;
	int                   n_mismatch, checks;

	rf_tag_config_and_control_regs u_dut (.mclk_in(mclk), .rst_in(rst), .nv_cfg_in(nv),
		.nv_cfg_out(nv_o), .i2c_req_in(req), .i2c_we_in(we), .system_area_select_in(sel),
		.i2c_addr_in(addr), .i2c_wdata_in(wd), .i2c_rdata_out(rd), .i2c_rvalid_out(rv),
		.i2c_active_in(act), .wcycle_start_in(wst), .wcycle_ok_in(wok), .rf_cmd_valid_in(cv),
		.rf_cmd_in(cmd), .rf_wdata_in(rwd), .rf_rdata_out(rrd), .rf_rvalid_out(rrv),
		.rf_sof_in(ev[0]), .rf_crc_in(ev[1]), .rf_bad_in(bad), .rf_exec_done_in(ev[2]),
		.rf_wr_start_in(ev[3]), .rf_answer_in(ev[4]), .rf_field_in(field),
		.rf_power_ok_in(pwr), .rf_activity_pin_out(pin), .rf_activity_pin_oe_out(oe),
		.harvest_out_en_out(hen), .sink_level_hi_out(shi), .sink_level_lo_out(slo));

	rf_frame_model u_rf (.mclk_in(mclk), .go_in(go), .kind_in(kind), .gap_in(gap),
		.ev_out(ev), .bad_out(bad), .busy_out(busy));

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Cycles with the pin pulled low, counted at each sampling edge
	// A frame start clears it here, so the count has a single driver
	always @(posedge mclk)
		if (go === 1'b1)
			cnt <= 8'h00;
		else if (oe === 1'b1)
			cnt <= cnt + 8'h01;

	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk1(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Drives always land 1 ns after the edge, so the next edge samples them cleanly
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task ser(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
		req = 1'b1;
		we = w;
		sel = s;
		addr = a;
		wd = d;
		tick(1);
		req = 1'b0;
		r = rd;
		v = rv;
		// One idle edge keeps the request from being lowered and raised in one step
		tick(1);
		if (!w)
			chk1("serial valid", 1'b1, v);
		else
			chk1("serial write quiet", 1'b0, v);
	endtask

	task sr(input logic s, input logic [15:0] a, input logic [7:0] e);
		ser(1'b0, s, a, 8'h00);
		chk8("serial read", e, r);
	endtask

	task rfc(input tag_cfg_pkg::rf_cmd_t c, input logic [7:0] d);
		cv = 1'b1;
		cmd = c;
		rwd = d;
		tick(1);
		cv = 1'b0;
		r = rrd;
		v = rrv;
		tick(1);
	endtask

	task rr(input tag_cfg_pkg::rf_cmd_t c, input logic [7:0] e);
		rfc(c, 8'h00);
		chk1("rf valid", 1'b1, v);
		chk8("rf read", e, r);
	endtask

	// Bounded wait for the frame source; running out ends the run
	task wait_idle;
		int i;
		i = 0;
		tick(1);
		while (busy !== 1'b0 && i < 80)
		begin
			tick(1);
			i++;
		end
		if (i >= 80)
		begin
			n_mismatch++;
			stop_test();
		end
		tick(2);
	endtask

	task start(input logic [1:0] k, input logic [3:0] g);
		kind = k;
		gap = g;
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask

	task frame(input logic [1:0] k, input logic [3:0] g, input logic [7:0] e);
		start(k, g);
		wait_idle();
		chk8("low cycles", e, cnt);
	endtask

	initial
	begin
		{req, we, sel, act, wst, wok, cv, go, wd, rwd, addr, kind, gap} = '0;
		{n_mismatch, checks} = '0;
		cmd = tag_cfg_pkg::RF_NOP_CMD;
		rst = 1'b1;
		nv = 8'hA3;
		field = 1'b1;
		pwr = 1'b1;
		tick(2);
		chk8("cfg in reset", 8'hF4, nv_o);
		rst = 1'b0;
		tick(2);
		chk8("cfg loaded", 8'hA3, nv_o);
		chk1("sink hi", 1'b1, shi);
		chk1("sink lo", 1'b1, slo);
		sr(1'b1, tag_cfg_pkg::CFG_ADDR, 8'hA3);
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h03);
		chk1("harvest on", 1'b1, hen);
		pwr = 1'b0;
		tick(2);
		chk1("harvest no power", 1'b0, hen);
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h01);
		pwr = 1'b1;
		sr(1'b0, tag_cfg_pkg::CFG_ADDR, 8'h00);
		ser(1'b1, 1'b0, tag_cfg_pkg::CTRL_ADDR, 8'h00);
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h03);
		ser(1'b1, 1'b1, tag_cfg_pkg::CTRL_ADDR, 8'hFE);
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h02);
		chk1("harvest off", 1'b0, hen);
		wst = 1'b1;
		tick(1);
		wst = 1'b0;
		wok = 1'b1;
		tick(1);
		wok = 1'b0;
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h82);
		field = 1'b0;
		tick(2);
		rr(tag_cfg_pkg::RF_READ_CONTROL_CMD, 8'h02);
		field = 1'b1;
		wst = 1'b1;
		tick(1);
		wst = 1'b0;
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h02);
		rfc(tag_cfg_pkg::RF_SET_HARVEST_EN_CMD, 8'h01);
		sr(1'b1, tag_cfg_pkg::CTRL_ADDR, 8'h03);
		frame(2'h0, 4'h2, 8'h06);
		frame(2'h1, 4'h3, 8'h04);
		act = 1'b1;
		frame(2'h0, 4'h1, 8'h00);
		act = 1'b0;
		start(2'h0, 4'h6);
		tick(3);
		chk1("pin low", 1'b1, oe);
		chk1("pin level", 1'b0, pin);
		field = 1'b0;
		tick(2);
		chk1("pin after field loss", 1'b0, oe);
		wait_idle();
		field = 1'b1;
		rfc(tag_cfg_pkg::RF_WRITE_HARVEST_CFG_CMD, 8'hFC);
		rfc(tag_cfg_pkg::RF_NOP_CMD, 8'hFF);
		chk1("nop answer", 1'b0, v);
		rr(tag_cfg_pkg::RF_READ_CONFIG_CMD, 8'hA4);
		chk1("sink hi new", 1'b0, shi);
		chk1("sink lo new", 1'b0, slo);
		rfc(tag_cfg_pkg::RF_WRITE_PIN_MODE_CMD, 8'h08);
		rr(tag_cfg_pkg::RF_READ_CONFIG_CMD, 8'hAC);
		frame(2'h2, 4'h2, 8'h03);
		frame(2'h0, 4'h2, 8'h00);
		act = 1'b1;
		frame(2'h2, 4'h1, 8'h00);
		act = 1'b0;
		ser(1'b1, 1'b1, tag_cfg_pkg::CFG_ADDR, 8'h53);
		sr(1'b1, tag_cfg_pkg::CFG_ADDR, 8'h53);
		chk1("sink hi serial", 1'b1, shi);
		frame(2'h1, 4'h1, 8'h02);
		stop_test();
	end
endmodule
